// ==== src/cfg_regs_pkg.sv ====
// package: register map, field layout and carriers of the configuration register group
package cfg_regs_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_REMAP_CFG  = 8'h5A;  // mgmt_ram_remap_config
  localparam logic [7:0] IDX_TRAP_CFG   = 8'h5B;  // io_trap_config
  localparam logic [7:0] IDX_TRAP0_BASE = 8'h5C;  // io_trap0_base
  localparam logic [7:0] IDX_TRAP1_BASE = 8'h5E;  // io_trap1_base
  localparam logic [7:0] IDX_DISK0      = 8'h60;  // disk_chan0_timing
  localparam logic [7:0] IDX_DISK1      = 8'h62;  // disk_chan1_timing
  localparam logic [7:0] IDX_AREA3      = 8'h64;  // exclusive_area3_setup

  // writable bit masks; reserved bits read as zero
  localparam logic [7:0]  REMAP_WMASK = 8'hBE;
  localparam logic [15:0] AREA3_WMASK = 16'hF0FF;

  // remap configuration field positions
  localparam int REMAP_BM_REQ  = 7;  // bus master request control
  localparam int REMAP_A20_SEL = 5;  // mask release in management mode
  localparam int REMAP_MODE_HI = 4;  // mode field 4:3
  localparam int REMAP_MODE_LO = 3;
  localparam int REMAP_INIT    = 2;  // initialization mode
  localparam int REMAP_EN      = 1;  // remapping enable

  // trap configuration field positions
  localparam int TRAP1_SIZE_HI = 7;
  localparam int TRAP1_SIZE_LO = 5;
  localparam int TRAP1_EN      = 4;
  localparam int TRAP0_SIZE_HI = 3;
  localparam int TRAP0_SIZE_LO = 1;
  localparam int TRAP0_EN      = 0;

  // exclusive area 3 field positions
  localparam int AREA3_TYPE    = 15;
  localparam int AREA3_SIZE_HI = 14;
  localparam int AREA3_SIZE_LO = 12;
  localparam int AREA3_START_HI = 7;

  // 64 KByte segment numbers (address bits 19:16) of the remap windows
  localparam logic [3:0] SEG_SRC_LOW  = 4'h6;
  localparam logic [3:0] SEG_SRC_HIGH = 4'hE;
  localparam logic [3:0] SEG_DST_A    = 4'hA;
  localparam logic [3:0] SEG_DST_B    = 4'hB;

  // wait count that a zero timing field stands for
  localparam logic [4:0] WAIT_ZERO_CLOCKS = 5'h10;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // AXI4-Lite request side (master to slave)
  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } axiReq_t;

  // AXI4-Lite answer side (slave to master)
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axiRsp_t;

  // processor cycle presented for checking
  typedef struct packed {
    logic        memValid;  // memory cycle this clock
    logic [31:0] memAddr;   // logical memory address
    logic        ioValid;   // I/O cycle this clock
    logic [15:0] ioAddr;    // I/O port address
  } cpuCycle_t;

  // eight decoded disk wait counts, 1..16 clocks
  typedef struct packed {
    logic [4:0] ch1SlaveRec;
    logic [4:0] ch1MasterRec;
    logic [4:0] ch1SlaveCmd;
    logic [4:0] ch1MasterCmd;
    logic [4:0] ch0SlaveRec;
    logic [4:0] ch0MasterRec;
    logic [4:0] ch0SlaveCmd;
    logic [4:0] ch0MasterCmd;
  } diskWait_t;

endpackage

// ==== src/mgmt_ram_iotrap_ide_timing_cfg.sv ====
// configuration register group: mgmt_ram remap, I/O traps, disk timing, exclusive area 3
// Operation
// - release address-20 mask in mgmt_mode when selected
// - mode field picks source and target 64K windows
// - init bit applies remapping outside mgmt_mode too
// - remap enable clear means never remap
// - enabled traps flag hits on I/O range
// - trap 1 size bits 7:5, powers of two
// - trap 1 hits only while bit 4 set
// - trap 0 size bits 3:1, enable bit 0
// - sixteen-bit trap bases at 5Ch, 5Eh, reset zero
// - channel 0 timing: four 4-bit fields
// - channel 1 timing uses same four-field layout
// - timing field value is clocks; zero means 16
// - area 3 type bit 15: onboard or bus
// - area 3 size: 000 off, 64K doubling
// - area 3 start bits 7:0 are A[23:16]
// - mgmt_mode accesses in window go to segment
`timescale 1ns/1ps

module mgmt_ram_iotrap_ide_timing_cfg (
  input  wire  logic                     clk_sys,
  input  wire  logic                     rst,
  input  wire  cfg_regs_pkg::axiReq_t    axiReq,
  output       cfg_regs_pkg::axiRsp_t    axiRsp,
  input  wire  logic                     mgmtMode,
  input  wire  logic                     addr20MaskIn,
  input  wire  cfg_regs_pkg::cpuCycle_t  cpuCycle,
  output logic                           addr20MaskOut,
  output logic                           remapHit,
  output logic [31:0]                    memPhysAddr,
  output logic                           area3Hit,
  output logic                           area3NonPostable,
  output logic [1:0]                     trapHit,
  output       cfg_regs_pkg::diskWait_t  diskWait
);
  import cfg_regs_pkg::*;

  // whole module state
  typedef struct packed {
    logic [7:0]  remapCfg;    // mgmt_ram_remap_config
    logic [7:0]  trapCfg;     // io_trap_config
    logic [15:0] trap0Base;   // io_trap0_base
    logic [15:0] trap1Base;   // io_trap1_base
    logic [15:0] disk0;       // disk_chan0_timing
    logic [15:0] disk1;       // disk_chan1_timing
    logic [15:0] area3;       // exclusive_area3_setup
    logic [7:0]  wrIdx;       // latched write index
    logic        awFull;      // write address held
    logic [31:0] wrData;      // latched write data
    logic [3:0]  wrStrb;      // latched byte strobes
    logic        wFull;       // write data held
    logic        bValid;      // write response pending
    logic [1:0]  bResp;
    logic        rValid;      // read response pending
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic        a20Out;      // registered mask output
    logic        remapHit;
    logic [31:0] physAddr;
    logic        area3Hit;
    logic        area3NonPost;
    logic [1:0]  trapHit;
    diskWait_t   diskWait;
  } state_t;

  state_t state_q;  // registered state
  state_t state_d;  // next state

  // timing field to clock count; zero stands for sixteen
  function automatic logic [4:0] waitClocks(input logic [3:0] field);
    waitClocks = (field == 4'h0) ? WAIT_ZERO_CLOCKS : {1'b0, field};
  endfunction

  // mask of address bits compared for a trap of the given size code
  function automatic logic [15:0] trapMask(input logic [2:0] sizeCode);
    trapMask = ~((16'h0001 << sizeCode) - 16'h0001);
  endfunction

  // register read mux; flag tells whether the index is mapped
  function automatic logic [32:0] readReg(input state_t s, input logic [7:0] idx);
    unique case (idx)
      IDX_REMAP_CFG:  readReg = {1'b1, 24'h000000, s.remapCfg};
      IDX_TRAP_CFG:   readReg = {1'b1, 24'h000000, s.trapCfg};
      IDX_TRAP0_BASE: readReg = {1'b1, 16'h0000, s.trap0Base};
      IDX_TRAP1_BASE: readReg = {1'b1, 16'h0000, s.trap1Base};
      IDX_DISK0:      readReg = {1'b1, 16'h0000, s.disk0};
      IDX_DISK1:      readReg = {1'b1, 16'h0000, s.disk1};
      IDX_AREA3:      readReg = {1'b1, 16'h0000, s.area3};
      default:        readReg = {1'b0, 32'h00000000};
    endcase
  endfunction

  // 16-bit byte-lane merge
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // bus handshakes, combinational from state
  assign axiRsp.awready = !state_q.awFull && !state_q.bValid;
  assign axiRsp.wready  = !state_q.wFull && !state_q.bValid;
  assign axiRsp.arready = !state_q.rValid;
  assign axiRsp.bvalid  = state_q.bValid;
  assign axiRsp.bresp   = state_q.bResp;
  assign axiRsp.rvalid  = state_q.rValid;
  assign axiRsp.rdata   = state_q.rData;
  assign axiRsp.rresp   = state_q.rResp;

  // decoded outputs come straight from flip-flops
  assign addr20MaskOut    = state_q.a20Out;
  assign remapHit         = state_q.remapHit;
  assign memPhysAddr      = state_q.physAddr;
  assign area3Hit         = state_q.area3Hit;
  assign area3NonPostable = state_q.area3NonPost;
  assign trapHit          = state_q.trapHit;
  assign diskWait         = state_q.diskWait;

  // combinational decode signals
  logic        remapActive;  // remapping applies this cycle
  logic [3:0]  srcSeg;       // selected logical segment
  logic [3:0]  dstSeg;       // selected physical segment
  logic        inWindow;     // address lies in the source window
  logic [2:0]  area3Size;    // area 3 size code
  logic [8:0]  area3Start;   // start in 64K units
  logic [8:0]  area3Len;     // length in 64K units
  logic [8:0]  area3Seg;     // address in 64K units
  logic [32:0] rdWord;       // read mux result with mapped flag
  logic        wrMapped;     // latched write index is mapped

  // remap window selection and activity
  always_comb begin
    remapActive = state_q.remapCfg[REMAP_EN] &&
                  (mgmtMode || state_q.remapCfg[REMAP_INIT]);
    srcSeg   = state_q.remapCfg[REMAP_MODE_HI] ? SEG_SRC_HIGH : SEG_SRC_LOW;
    dstSeg   = state_q.remapCfg[REMAP_MODE_LO] ? SEG_DST_B : SEG_DST_A;
    inWindow = (cpuCycle.memAddr[31:20] == 12'h000) &&
               (cpuCycle.memAddr[19:16] == srcSeg);
  end

  // exclusive area 3 range terms and register map lookups
  always_comb begin
    area3Size  = state_q.area3[AREA3_SIZE_HI:AREA3_SIZE_LO];
    area3Start = {1'b0, state_q.area3[AREA3_START_HI:0]};
    area3Len   = (area3Size == 3'h0) ? 9'h000 : (9'h001 << (area3Size - 3'h1));
    area3Seg   = {1'b0, cpuCycle.memAddr[23:16]};
    rdWord     = readReg(state_q, axiReq.araddr[9:2]);
    wrMapped   = readReg(state_q, state_q.wrIdx) >> 32 != 33'h0;
  end

  // next-state logic: bus slave, register writes and cycle decode
  always_comb begin
    state_d = state_q;

    // write address channel
    if (axiReq.awvalid && axiRsp.awready) begin
      state_d.wrIdx  = axiReq.awaddr[9:2];
      state_d.awFull = 1'b1;
    end
    // write data channel
    if (axiReq.wvalid && axiRsp.wready) begin
      state_d.wrData = axiReq.wdata;
      state_d.wrStrb = axiReq.wstrb;
      state_d.wFull  = 1'b1;
    end
    // both halves held: perform the write and answer
    if (state_q.awFull && state_q.wFull) begin
      state_d.awFull = 1'b0;
      state_d.wFull  = 1'b0;
      state_d.bValid = 1'b1;
      state_d.bResp  = wrMapped ? RESP_OKAY : RESP_SLVERR;
      unique case (state_q.wrIdx)
        IDX_REMAP_CFG: begin
          // bus-master request bit stored as written
          if (state_q.wrStrb[0]) state_d.remapCfg = state_q.wrData[7:0] & REMAP_WMASK;
        end
        IDX_TRAP_CFG: begin
          if (state_q.wrStrb[0]) state_d.trapCfg = state_q.wrData[7:0];
        end
        IDX_TRAP0_BASE: begin
          state_d.trap0Base = merge16(state_q.trap0Base, state_q.wrData, state_q.wrStrb);
        end
        IDX_TRAP1_BASE: begin
          state_d.trap1Base = merge16(state_q.trap1Base, state_q.wrData, state_q.wrStrb);
        end
        IDX_DISK0: begin
          state_d.disk0 = merge16(state_q.disk0, state_q.wrData, state_q.wrStrb);
        end
        IDX_DISK1: begin
          state_d.disk1 = merge16(state_q.disk1, state_q.wrData, state_q.wrStrb);
        end
        IDX_AREA3: begin
          state_d.area3 = merge16(state_q.area3, state_q.wrData, state_q.wrStrb) & AREA3_WMASK;
        end
        default: begin
          // unmapped index: nothing stored, error answer
        end
      endcase
    end
    // write response retires on bready
    if (state_q.bValid && axiReq.bready) begin
      state_d.bValid = 1'b0;
    end

    // read: data captured when address is taken
    if (axiReq.arvalid && axiRsp.arready) begin
      state_d.rValid = 1'b1;
      state_d.rData  = rdWord[31:0];
      state_d.rResp  = rdWord[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (state_q.rValid && axiReq.rready) begin
      state_d.rValid = 1'b0;
    end

    // address-20 mask: released in mgmt_mode when selected, else passed through
    state_d.a20Out = (mgmtMode && state_q.remapCfg[REMAP_A20_SEL]) ? 1'b0 : addr20MaskIn;

    // memory cycle remapping
    state_d.remapHit = cpuCycle.memValid && remapActive && inWindow;
    state_d.physAddr = state_d.remapHit ?
                       {cpuCycle.memAddr[31:20], dstSeg, cpuCycle.memAddr[15:0]} :
                       cpuCycle.memAddr;

    // exclusive area 3 check on the same memory cycle
    state_d.area3Hit = cpuCycle.memValid && (area3Size != 3'h0) &&
                       (area3Seg >= area3Start) &&
                       (area3Seg < (area3Start + area3Len));
    state_d.area3NonPost = state_d.area3Hit && state_q.area3[AREA3_TYPE];

    // I/O trap hits, one-cycle pulses
    state_d.trapHit[0] = cpuCycle.ioValid && state_q.trapCfg[TRAP0_EN] &&
      (((cpuCycle.ioAddr ^ state_q.trap0Base) &
        trapMask(state_q.trapCfg[TRAP0_SIZE_HI:TRAP0_SIZE_LO])) == 16'h0000);
    state_d.trapHit[1] = cpuCycle.ioValid && state_q.trapCfg[TRAP1_EN] &&
      (((cpuCycle.ioAddr ^ state_q.trap1Base) &
        trapMask(state_q.trapCfg[TRAP1_SIZE_HI:TRAP1_SIZE_LO])) == 16'h0000);

    // disk wait counts from the timing registers
    state_d.diskWait.ch0SlaveRec  = waitClocks(state_q.disk0[15:12]);
    state_d.diskWait.ch0MasterRec = waitClocks(state_q.disk0[11:8]);
    state_d.diskWait.ch0SlaveCmd  = waitClocks(state_q.disk0[7:4]);
    state_d.diskWait.ch0MasterCmd = waitClocks(state_q.disk0[3:0]);
    state_d.diskWait.ch1SlaveRec  = waitClocks(state_q.disk1[15:12]);
    state_d.diskWait.ch1MasterRec = waitClocks(state_q.disk1[11:8]);
    state_d.diskWait.ch1SlaveCmd  = waitClocks(state_q.disk1[7:4]);
    state_d.diskWait.ch1MasterCmd = waitClocks(state_q.disk1[3:0]);
  end

  // state register, synchronous reset to all zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // address-20 mask released one cycle after mgmt_mode with select set
  property p_a20Release;
    (mgmtMode && state_q.remapCfg[REMAP_A20_SEL]) |=> !addr20MaskOut;
  endproperty
  a_a20Release: assert property (p_a20Release) else $error("mask not released");

  // mask passes through when not selected
  property p_a20Pass;
    !state_q.remapCfg[REMAP_A20_SEL] |=> (addr20MaskOut == $past(addr20MaskIn));
  endproperty
  a_a20Pass: assert property (p_a20Pass) else $error("mask altered");

  // remap hit lands on the selected segment
  property p_remapTarget;
    remapHit |-> (memPhysAddr[19:16] ==
                  ($past(state_q.remapCfg[REMAP_MODE_LO]) ? SEG_DST_B : SEG_DST_A));
  endproperty
  a_remapTarget: assert property (p_remapTarget) else $error("wrong target segment");

  // remap hit only from the selected source segment
  property p_remapSource;
    remapHit |-> ($past(cpuCycle.memAddr[19:16]) ==
                  ($past(state_q.remapCfg[REMAP_MODE_HI]) ? SEG_SRC_HIGH : SEG_SRC_LOW));
  endproperty
  a_remapSource: assert property (p_remapSource) else $error("wrong source window");

  // initialization mode remaps outside mgmt_mode
  sequence s_initAccess;
    cpuCycle.memValid && inWindow && !mgmtMode &&
    state_q.remapCfg[REMAP_EN] && state_q.remapCfg[REMAP_INIT];
  endsequence
  property p_initRemap;
    s_initAccess |=> remapHit;
  endproperty
  a_initRemap: assert property (p_initRemap) else $error("init mode did not remap");

  // no remapping while disabled
  property p_remapOff;
    !state_q.remapCfg[REMAP_EN] |=> !remapHit;
  endproperty
  a_remapOff: assert property (p_remapOff) else $error("remap while disabled");

  // trap 1 hit needs its enable in the previous cycle
  property p_trap1Enable;
    trapHit[1] |-> $past(state_q.trapCfg[TRAP1_EN]);
  endproperty
  a_trap1Enable: assert property (p_trap1Enable) else $error("trap 1 hit while off");

  // trap 0 hit matches base above the size bits
  property p_trap0Match;
    trapHit[0] |-> ((($past(cpuCycle.ioAddr) ^ $past(state_q.trap0Base)) &
                     trapMask($past(state_q.trapCfg[TRAP0_SIZE_HI:TRAP0_SIZE_LO])))
                    == 16'h0000);
  endproperty
  a_trap0Match: assert property (p_trap0Match) else $error("trap 0 out of range");

  // zero timing field decodes to sixteen clocks
  property p_waitZero;
    (state_q.disk0[3:0] == 4'h0) |=> (diskWait.ch0MasterCmd == WAIT_ZERO_CLOCKS);
  endproperty
  a_waitZero: assert property (p_waitZero) else $error("zero field not 16");

  // area 3 disabled never hits
  property p_area3Off;
    (state_q.area3[AREA3_SIZE_HI:AREA3_SIZE_LO] == 3'h0) |=> !area3Hit;
  endproperty
  a_area3Off: assert property (p_area3Off) else $error("area 3 hit while off");

  // write response holds until taken
  property p_bHold;
    (axiRsp.bvalid && !axiReq.bready) |=> axiRsp.bvalid;
  endproperty
  a_bHold: assert property (p_bHold) else $error("bvalid dropped");

  // trap 0 hit needs its enable in the previous cycle
  property p_trap0Enable;
    trapHit[0] |-> $past(state_q.trapCfg[TRAP0_EN]);
  endproperty
  a_trap0Enable: assert property (p_trap0Enable) else $error("trap 0 hit while off");

  // no I/O cycle, so no trap hit in the next cycle
  property p_trapIdle;
    !cpuCycle.ioValid |=> (trapHit == 2'h0);
  endproperty
  a_trapIdle: assert property (p_trapIdle) else $error("trap hit while idle");

  // no memory cycle, so no remap hit in the next cycle
  property p_remapIdle;
    !cpuCycle.memValid |=> !remapHit;
  endproperty
  a_remapIdle: assert property (p_remapIdle) else $error("remap hit while idle");

  // remapping keeps the offset inside the 64K segment
  property p_remapOffset;
    remapHit |-> (memPhysAddr[15:0] == $past(cpuCycle.memAddr[15:0]));
  endproperty
  a_remapOffset: assert property (p_remapOffset) else $error("offset altered");

  // area 3 treatment follows the type bit
  property p_area3Type;
    area3Hit |-> (area3NonPostable == $past(state_q.area3[AREA3_TYPE]));
  endproperty
  a_area3Type: assert property (p_area3Type) else $error("area 3 type wrong");

  // nonzero channel 1 field gives its own clock count
  property p_waitCount;
    (state_q.disk1[15:12] != 4'h0) |=>
      (diskWait.ch1SlaveRec == {1'b0, $past(state_q.disk1[15:12])});
  endproperty
  a_waitCount: assert property (p_waitCount) else $error("wait count wrong");

endmodule

// ==== tb/cpu_model.sv ====
// host processor model issuing single memory and I/O cycles
`timescale 1ns/1ps

module cpu_model (
  input  wire  logic                     clk_sys,
  output       cfg_regs_pkg::cpuCycle_t  cpuCycle
);
  import cfg_regs_pkg::*;

  // idle bus at time zero
  initial begin
    cpuCycle = '0;
  end

  // one cycle of one clock; afterwards the address lines show the inverse value
  task automatic issue(input logic isIo, input logic [31:0] addr);
    @(posedge clk_sys);
    cpuCycle.memValid <= !isIo;
    cpuCycle.ioValid  <= isIo;
    cpuCycle.memAddr  <= addr;
    cpuCycle.ioAddr   <= addr[15:0];
    @(posedge clk_sys);
    cpuCycle.memValid <= 1'b0;
    cpuCycle.ioValid  <= 1'b0;
    cpuCycle.memAddr  <= ~addr;
    cpuCycle.ioAddr   <= ~addr[15:0];
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench of the configuration register group
`timescale 1ns/1ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end

module tb;
  import cfg_regs_pkg::*;

  logic      clk_sys;        // 50 MHz system clock
  logic      rst;            // synchronous reset
  axiReq_t   axiReq;         // register bus requests
  axiRsp_t   axiRsp;         // register bus answers
  logic      mgmtMode;       // management mode flag
  logic      addr20MaskIn;   // mask request from the chip
  cpuCycle_t cpuCycle;       // processor cycles from the model
  logic      addr20MaskOut;
  logic      remapHit;
  logic [31:0] memPhysAddr;
  logic      area3Hit;
  logic      area3NonPostable;
  logic [1:0] trapHit;
  diskWait_t diskWait;
  int        miscompares = 0;
  int        comparisons = 0;
  int        cycles = 0;     // timeout counter

  mgmt_ram_iotrap_ide_timing_cfg i_mgmt_ram_iotrap_ide_timing_cfg (
    .clk_sys(clk_sys), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp), .mgmtMode(mgmtMode),
    .addr20MaskIn(addr20MaskIn), .cpuCycle(cpuCycle), .addr20MaskOut(addr20MaskOut),
    .remapHit(remapHit), .memPhysAddr(memPhysAddr), .area3Hit(area3Hit),
    .area3NonPostable(area3NonPostable), .trapHit(trapHit), .diskWait(diskWait));

  cpu_model i_cpu_model (.clk_sys(clk_sys), .cpuCycle(cpuCycle));

  // clock generator
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // a hang ends the run as a mismatch
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // verdict and end of run
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // AXI4-Lite write; address and data offered together, bready held until bvalid
  task automatic axiWrite(input logic [7:0] idx, input logic [15:0] data,
                          output logic [1:0] resp);
    logic aw, w, awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clk_sys);
    axiReq.awaddr  <= {2'h0, idx, 2'h0};
    axiReq.awvalid <= 1'b1;
    axiReq.wdata   <= {16'h0000, data};
    axiReq.wstrb   <= 4'hF;
    axiReq.wvalid  <= 1'b1;
    axiReq.bready  <= 1'b1;
    while (!(awDone && wDone)) begin
      @(negedge clk_sys);
      aw = axiReq.awvalid && (axiRsp.awready === 1'b1);
      w = axiReq.wvalid && (axiRsp.wready === 1'b1);
      @(posedge clk_sys);
      if (aw) axiReq.awvalid <= 1'b0;
      if (w) axiReq.wvalid <= 1'b0;
      awDone = awDone | aw;
      wDone = wDone | w;
    end
    do @(negedge clk_sys); while (axiRsp.bvalid !== 1'b1);
    resp = axiRsp.bresp;
    @(posedge clk_sys);
    axiReq.bready <= 1'b0;
  endtask

  // AXI4-Lite read; rready held until rvalid
  task automatic axiRead(input logic [7:0] idx, output logic [31:0] data,
                         output logic [1:0] resp);
    @(posedge clk_sys);
    axiReq.araddr  <= {2'h0, idx, 2'h0};
    axiReq.arvalid <= 1'b1;
    axiReq.rready  <= 1'b1;
    do @(negedge clk_sys); while (axiRsp.arready !== 1'b1);
    @(posedge clk_sys);
    axiReq.arvalid <= 1'b0;
    do @(negedge clk_sys); while (axiRsp.rvalid !== 1'b1);
    data = axiRsp.rdata;
    resp = axiRsp.rresp;
    @(posedge clk_sys);
    axiReq.rready <= 1'b0;
  endtask

  // write expecting an okay answer
  task automatic wr(input logic [7:0] idx, input logic [15:0] data);
    logic [1:0] resp;
    axiWrite(idx, data, resp);
    `CHK("bresp", RESP_OKAY, resp)
  endtask

  // read and compare value and answer
  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] data;
    logic [1:0]  resp;
    axiRead(idx, data, resp);
    `CHK("rdata", exp, data)
    `CHK("rresp", er, resp)
  endtask

  // one processor cycle, outputs judged one cycle later
  task automatic cpu(input logic isIo, input logic [31:0] a);
    i_cpu_model.issue(isIo, a);
    @(negedge clk_sys);
  endtask

  // memory cycle: remap result
  task automatic remapChk(input logic [31:0] a, input logic hit, input logic [31:0] phys);
    cpu(1'b0, a);
    `CHK("remapHit", hit, remapHit)
    `CHK("memPhysAddr", phys, memPhysAddr)
  endtask

  // memory cycle: exclusive area result
  task automatic areaChk(input logic [31:0] a, input logic hit, input logic np);
    cpu(1'b0, a);
    `CHK("area3Hit", hit, area3Hit)
    `CHK("area3NonPostable", np, area3NonPostable)
  endtask

  // I/O cycle: trap result
  task automatic trapChk(input logic [31:0] a, input logic [1:0] exp);
    cpu(1'b1, a);
    `CHK("trapHit", exp, trapHit)
  endtask

  // change management mode and let the mask output follow
  task automatic setMgmt(input logic v);
    @(posedge clk_sys);
    mgmtMode <= v;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // reset values, then write/read masks and an unmapped place
  task automatic tRegs;
    logic [7:0]  idx[7] = '{IDX_REMAP_CFG, IDX_TRAP_CFG, IDX_TRAP0_BASE, IDX_TRAP1_BASE,
                           IDX_DISK0, IDX_DISK1, IDX_AREA3};
    logic [15:0] val[7] = '{16'h00FF, 16'h00FF, 16'hA5C3, 16'h5A3C, 16'h1234, 16'h8765, 16'hFFFF};
    logic [15:0] msk[7] = '{16'h00BE, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hF0FF};
    logic [1:0]  resp;
    for (int i = 0; i < 7; i++) rdChk(idx[i], 32'h0, RESP_OKAY);
    `CHK("diskWait", {8{5'h10}}, diskWait)
    for (int i = 0; i < 7; i++) wr(idx[i], val[i]);
    for (int i = 0; i < 7; i++) rdChk(idx[i], {16'h0000, val[i] & msk[i]}, RESP_OKAY);
    axiWrite(8'h66, 16'hFFFF, resp);
    `CHK("bresp", RESP_SLVERR, resp)
    rdChk(8'h66, 32'h0, RESP_SLVERR);
  endtask

  // disk timing fields decoded to clock counts
  task automatic tDisk;
    wr(IDX_DISK0, 16'h0F18);
    wr(IDX_DISK1, 16'h2E70);
    @(negedge clk_sys);
    `CHK("diskWait", {5'h02, 5'h0E, 5'h07, 5'h10, 5'h10, 5'h0F, 5'h01, 5'h08}, diskWait)
  endtask

  // every remap mode, enable and initialization cases
  task automatic tRemap;
    logic [31:0] src;
    setMgmt(1'b1);
    for (int m = 0; m < 4; m++) begin
      src = (m > 1) ? 32'h000E1234 : 32'h00061234;
      wr(IDX_REMAP_CFG, 16'h0082 | 16'(m * 8));
      remapChk(src, 1'b1, (m % 2) ? 32'h000B1234 : 32'h000A1234);
      remapChk(src ^ 32'h00080000, 1'b0, src ^ 32'h00080000);
    end
    wr(IDX_REMAP_CFG, 16'h0084);
    remapChk(32'h00061234, 1'b0, 32'h00061234);
    setMgmt(1'b0);
    wr(IDX_REMAP_CFG, 16'h0086);
    remapChk(32'h00061234, 1'b1, 32'h000A1234);
    wr(IDX_REMAP_CFG, 16'h0082);
    remapChk(32'h00061234, 1'b0, 32'h00061234);
  endtask

  // mask release in management mode
  task automatic tA20;
    @(posedge clk_sys);
    addr20MaskIn <= 1'b1;
    wr(IDX_REMAP_CFG, 16'h00A2);
    setMgmt(1'b1);
    `CHK("addr20MaskOut", 1'b0, addr20MaskOut)
    setMgmt(1'b0);
    `CHK("addr20MaskOut", 1'b1, addr20MaskOut)
    wr(IDX_REMAP_CFG, 16'h0082);
    setMgmt(1'b1);
    `CHK("addr20MaskOut", 1'b1, addr20MaskOut)
    setMgmt(1'b0);
  endtask

  // both traps at every size, top of each range and one past it, then disabled
  task automatic tTrap;
    wr(IDX_TRAP0_BASE, 16'h1280);
    wr(IDX_TRAP1_BASE, 16'h3400);
    for (int s = 0; s < 8; s++) begin
      wr(IDX_TRAP_CFG, 16'(s * 32 + 16 + s * 2 + 1));
      trapChk(32'h1280 + (1 << s) - 1, 2'h1);
      trapChk(32'h1280 + (1 << s), 2'h0);
      trapChk(32'h3400 + (1 << s) - 1, 2'h2);
      trapChk(32'h3400 + (1 << s), 2'h0);
    end
    wr(IDX_TRAP_CFG, 16'h00EE);
    trapChk(32'h00001280, 2'h0);
    trapChk(32'h00003400, 2'h0);
  endtask

  // exclusive area 3 bounds, type and size codes
  task automatic tArea;
    wr(IDX_AREA3, 16'h3020);
    areaChk(32'h0023FFFF, 1'b1, 1'b0);
    areaChk(32'h00240000, 1'b0, 1'b0);
    areaChk(32'h001FFFFF, 1'b0, 1'b0);
    wr(IDX_AREA3, 16'hB020);
    areaChk(32'h00200000, 1'b1, 1'b1);
    wr(IDX_AREA3, 16'h7020);
    areaChk(32'h005FFFFF, 1'b1, 1'b0);
    areaChk(32'h00600000, 1'b0, 1'b0);
    wr(IDX_AREA3, 16'h0020);
    areaChk(32'h00200000, 1'b0, 1'b0);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    axiReq = '0;
    mgmtMode = 1'b0;
    addr20MaskIn = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    tRegs();
    tDisk();
    tRemap();
    tA20();
    tTrap();
    tArea();
    wrap_up();
  end
endmodule
